// ### design/rops_output_select.sv
// APB slave holding the output selectors and the mux for remappable pins 16 to 19
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "rops_regs.svh"

module rops_output_select
	import rops_pkg::*;
#(
	parameter int          NUM_FUNC    = 32,    // Peripheral output function count
	parameter bit          HAS_PINS    = 1'b1   // Largest pin-count variant fitted
) (
	input  wire logic                 clk_i,            // 100 MHz clock
	input  wire logic                 rstn_i,           // Async reset, active low
	input  wire logic                 psel_i,           // APB select
	input  wire logic                 penable_i,        // APB enable
	input  wire logic                 pwrite_i,         // APB write
	input  wire logic [11:0]          paddr_i,          // APB byte address
	input  wire logic [31:0]          pwdata_i,         // APB write data
	output logic      [31:0]          prdata_o,         // APB read data
	output logic                      pready_o,         // APB ready
	output logic                      pslverr_o,        // APB error
	input  wire logic [NUM_FUNC-1:0]  periph_out_i,     // Peripheral outputs by function number
	input  wire logic [3:0]           port_out_i,       // Port latch for pins 16..19
	output logic      [3:0]           pin_out_o,        // Drive to pins 16..19
	output logic      [3:0]           pin_remapped_o    // Pin carries a peripheral output
);

	rops_pair_t sel_a_r, sel_a_nxt;   // pins 16 (lo) / 17 (hi)
	rops_pair_t sel_b_r, sel_b_nxt;   // pins 18 (lo) / 19 (hi)
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        hit_a, hit_b, access;
	rops_func_t  sel [4];
	logic [3:0]  pin_r, pin_nxt;
	logic [3:0]  remap_r, remap_nxt;

	// Only the implemented field bits of the 16-bit reset value are stored
	localparam logic [15:0] SEL_RST = `ROPS_SEL_RESET;

	assign access = psel_i & penable_i;
	assign hit_a  = (paddr_i == `ROPS_SEL_16_17_OFS);
	assign hit_b  = (paddr_i == `ROPS_SEL_18_19_OFS);

	// Zero-wait slave: every access finishes in its first access cycle
	assign pready_o  = 1'b1;
	assign prdata_o  = prdata_r;
	assign pslverr_o = pslverr_r;

	function automatic rops_pair_t pack_sel(input logic [31:0] d);
		rops_pair_t p;
		p.hi_sel = d[`ROPS_HI_FIELD_LSB +: `ROPS_FIELD_W];
		p.lo_sel = d[`ROPS_LO_FIELD_LSB +: `ROPS_FIELD_W];
		return p;
	endfunction

	function automatic logic [31:0] unpack_sel(input rops_pair_t p);
		logic [31:0] d;
		d = 32'h0000_0000;
		d[`ROPS_HI_FIELD_LSB +: `ROPS_FIELD_W] = p.hi_sel;
		d[`ROPS_LO_FIELD_LSB +: `ROPS_FIELD_W] = p.lo_sel;
		return d;
	endfunction

	always_comb begin
		sel_a_nxt   = sel_a_r;
		sel_b_nxt   = sel_b_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel_i && !penable_i) begin
			// Setup cycle: latch read data so it stands through the access cycle
			prdata_nxt = 32'h0000_0000;
			if (!pwrite_i && HAS_PINS) begin
				if (hit_a)
					prdata_nxt = unpack_sel(sel_a_r);
				else if (hit_b)
					prdata_nxt = unpack_sel(sel_b_r);
			end
			pslverr_nxt = !(hit_a || hit_b);
		end else if (access) begin
			pslverr_nxt = pslverr_r;
			if (pwrite_i && HAS_PINS) begin
				if (hit_a)
					sel_a_nxt = pack_sel(pwdata_i);
				if (hit_b)
					sel_b_nxt = pack_sel(pwdata_i);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_a_r   <= {SEL_RST[12:8], SEL_RST[4:0]};
			sel_b_r   <= {SEL_RST[12:8], SEL_RST[4:0]};
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			sel_a_r   <= sel_a_nxt;
			sel_b_r   <= sel_b_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign sel[0] = sel_a_r.lo_sel;
	assign sel[1] = sel_a_r.hi_sel;
	assign sel[2] = sel_b_r.lo_sel;
	assign sel[3] = sel_b_r.hi_sel;

	// Registered pin drive avoids glitches while a selector is rewritten
	for (genvar p = 0; p < 4; p++) begin : g_pin
		assign remap_nxt[p] = HAS_PINS && sel[p] != 5'h00 && int'(sel[p]) < NUM_FUNC;
		assign pin_nxt[p]   = remap_nxt[p] ? periph_out_i[sel[p]] : port_out_i[p];
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_r   <= 4'h0;
			remap_r <= 4'h0;
		end else begin
			pin_r   <= pin_nxt;
			remap_r <= remap_nxt;
		end
	end

	assign pin_out_o      = pin_r;
	assign pin_remapped_o = remap_r;

endmodule

// ### inc/rops_pkg.sv
// Types shared by the remappable output selector
package rops_pkg;

	typedef logic [4:0] rops_func_t;

	typedef struct packed {
		rops_func_t hi_sel;
		rops_func_t lo_sel;
	} rops_pair_t;

endpackage

// ### inc/rops_regs.svh
// Register offsets, field positions and reset values of the remappable output selector
`ifndef ROPS_REGS_SVH
`define ROPS_REGS_SVH

`define ROPS_SEL_16_17_OFS   12'h000
`define ROPS_SEL_18_19_OFS   12'h004
`define ROPS_LO_FIELD_LSB    0
`define ROPS_HI_FIELD_LSB    8
`define ROPS_FIELD_W         5
`define ROPS_SEL_RESET       16'h0000
`define ROPS_FIELD_MASK      16'h1F1F

`endif

// ### tb/rops_chk_properties.sv
// Checker for the remappable output selector
`timescale 1ns/100ps
module rops_chk #(parameter int NUM_FUNC = 32) (
	input logic                clk_i, rstn_i, psel_i, penable_i, pwrite_i, // Clock, reset, APB controls
	input logic [11:0]         paddr_i,                                     // APB address
	input logic [31:0]         pwdata_i, prdata_o,                          // APB data
	input logic [NUM_FUNC-1:0] periph_out_i,                                // Peripheral outputs
	input logic [3:0]          port_out_i, pin_out_o, pin_remapped_o        // Pin side
);
	logic [19:0] sel_r;
	logic [3:0]  exp_pin, exp_map;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// Shadow of the selectors, pin16 field at the bottom
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) sel_r <= 20'h00000;
		else if (psel_i && penable_i && pwrite_i && paddr_i inside {12'h000, 12'h004})
			sel_r[(paddr_i[2] ? 10 : 0) +: 10] <= {pwdata_i[12:8], pwdata_i[4:0]};
	end
	always_comb
		for (int i = 0; i < 4; i++) begin
			exp_map[i] = sel_r[i*5 +: 5] != 5'h00 && sel_r[i*5 +: 5] < NUM_FUNC;
			exp_pin[i] = exp_map[i] ? periph_out_i[sel_r[i*5 +: 5]] : port_out_i[i];
		end
	AST_PIN19: assert property ($past(rstn_i) |-> pin_out_o[3] == $past(exp_pin[3])) else $error("pin 19 drive");
	AST_PIN18: assert property ($past(rstn_i) |-> pin_out_o[2] == $past(exp_pin[2])) else $error("pin 18 drive");
	AST_PIN_LO: assert property ($past(rstn_i) |-> pin_out_o[1:0] == $past(exp_pin[1:0])) else $error("pin 16/17");
	AST_RSVD: assert property (prdata_o[31:13] == 19'h00000 && prdata_o[7:5] == 3'h0) else $error("reserved bits");
	AST_MAP: assert property ($past(rstn_i) |-> pin_remapped_o == $past(exp_map)) else $error("remap flag");
	AST_RST: assert property (disable iff (1'b0) !rstn_i |-> pin_out_o == 4'h0 && prdata_o == 32'h0) else $error("reset");
endmodule
bind rops_output_select rops_chk #(.NUM_FUNC(NUM_FUNC)) u_chk (.*);

// ### tb/tb_top.sv
// Directed bench for the remappable output selector
`timescale 1ns/100ps
module tb_top;
	logic        clk_i = 0, rstn_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, periph_out_i = 32'hA5C30F96, rd;
	logic [3:0]  port_out_i = 4'hA, pin_out_o, pin_remapped_o;
	logic        err;
	int          error_cnt = 0, cmp_count = 0;
	rops_output_select i_dut (.*);
	always #5 clk_i = ~clk_i;
	task chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", n, e, g);
			error_cnt++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
	endtask
	task pins(input logic [3:0] e);
		repeat (2) @(posedge clk_i);
		#1 chk("pins", {28'h0, e}, {28'h0, pin_out_o});
	endtask
	task t_reset;
		apb(0, 12'h000, 0); chk("sel16_17", 32'h0, rd);
		apb(0, 12'h004, 0); chk("sel18_19", 32'h0, rd);
		chk("slverr_ok", 32'h0, {31'h0, err});
		apb(0, 12'h008, 0); chk("unmapped", 32'h0, rd);
		chk("slverr", 32'h1, {31'h0, err});
		pins(4'hA);
		chk("remap", 32'h0, {28'h0, pin_remapped_o});
		$display("test reset done");
	endtask
	task t_hi;
		apb(1, 12'h004, 32'hFFFFE3E2);
		apb(0, 12'h004, 0); chk("sel18_19", 32'h0302, rd);
		pins(4'h6);
		chk("remap", 32'hC, {28'h0, pin_remapped_o});
		$display("test hi done");
	endtask
	task t_lo;
		apb(1, 12'h000, 32'h00001F07);
		apb(0, 12'h000, 0); chk("sel16_17", 32'h1F07, rd);
		apb(1, 12'h004, 0); pins(4'hB);
		chk("remap", 32'h3, {28'h0, pin_remapped_o});
		$display("test lo done");
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rstn_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		t_reset;
		t_hi;
		t_lo;
		print_verdict;
	end
	initial begin
		#20000;
		error_cnt++;
		print_verdict;
	end
endmodule
